/* bench/bfd_host.sv */
// bus master model of the microcontroller on the register port
// assumes the port is sampled on the rising edge of clk
`timescale 1ns/1ps
`default_nettype none
module bfd_host (
  input  wire logic                clk,
  output var bfd_pkg::bfd_bus_type bus
);
  initial bus = '0;

  // strobe for one cycle then idle, so calls back to back never collide
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    bus <= '0;
  endtask
endmodule
`default_nettype wire

/* bench/booster_diagnostic_flags_bench.sv */
// self-checking bench for the booster diagnostic flag block
// assumes bfd_host as bus master; monitors are driven on the rising edge
`timescale 1ns/1ps
`default_nettype none
module booster_diagnostic_flags_bench;
  logic                 clk = 1'b0;
  logic                 reset_n = 1'b0;
  bfd_pkg::bfd_bus_type bus;
  bfd_pkg::bfd_mon_type mon = '0;
  logic                 ser_err = 1'b0;
  logic                 fsm = 1'b0;
  logic                 sam = 1'b0;
  logic [15:0]          rdat;
  logic [2:0]           drv;
  logic [2:0]           uvt;
  logic [3:0]           setp;
  logic [15:0]          qe[$];
  logic [15:0]          qm[$];
  logic                 rd_pend = 1'b0;
  logic [15:0]          c;
  logic [31:0]          sd = 32'hbebf;
  int                   fails = 0;
  int                   total_checks = 0;

  always #5 clk = ~clk;
  bfd_host host (.clk(clk), .bus(bus));
  bfd_flags #(.BLANK_CYC(20)) DUT (
    .clk(clk), .reset_n(reset_n), .bus(bus), .read_data(rdat),
    .mon(mon), .serial_error(ser_err), .fail_safe_mode(fsm),
    .stand_alone_mode(sam), .phase_drive(drv),
    .gate_drive_uv_threshold(uvt), .gate_drive_setpoint(setp));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic cmp(input string n, input logic [15:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic r(input logic [7:0] a, input logic [15:0] m, e);
    qm.push_back(m);
    qe.push_back(e);
    host.rd(a);
  endtask

  // sync takes four edges, shutdown state one, block release one, drive one
  task automatic ck(input logic [2:0] e);
    repeat (8) @(posedge clk);
    cmp("phase_drive", {13'h0, e}, {13'h0, drv});
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk)
  begin
    rd_pend <= bus.rd;
    if (rd_pend && qe.size() > 0)
      cmp("read_data", qe.pop_front(), rdat & qm.pop_front());
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    final_report();
  end

  initial
  begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    c = 16'h2b07;
    host.wr(8'h00, c);
    mon.drv_uv <= 1'b1;
    ck(3'h7);
    cmp("uv_threshold", 16'h3, {13'h0, uvt});
    cmp("setpoint", 16'h5, {12'h0, setp});
    repeat (20) @(posedge clk);
    ck(3'h0);
    host.wr(8'h00, c & 16'hf8ff);
    ck(3'h7);
    mon.drv_uv <= 1'b0;
    r(8'h0a, 16'h0008, 16'h0008);
    host.wr(8'h0a, 16'h0008);
    r(8'h0a, 16'h0008, 16'h0000);
    r(8'h00, 16'hffff, c & 16'hf8ff);
    r(8'h55, 16'hffff, 16'h0000);
    mon.tw <= 1'b1;
    ck(3'h7);
    mon.tw <= 1'b0;
    ck(3'h7);
    r(8'h0a, 16'h0001, 16'h0001);
    mon.thermal_shutdown_flag <= 1'b1;
    mon.tw <= 1'b1;
    ck(3'h0);
    mon.thermal_shutdown_flag <= 1'b0;
    ck(3'h0);
    mon.tw <= 1'b0;
    ck(3'h0);
    r(8'h0a, 16'h0002, 16'h0002);
    host.wr(8'h00, 16'h0000);
    host.wr(8'h00, c);
    ck(3'h0);
    host.wr(8'h0a, 16'h0003);
    host.wr(8'h00, 16'h0000);
    host.wr(8'h00, c);
    ck(3'h7);
    for (int m = 0; m < 3; m++)
    begin
      host.wr(8'h00, (m == 0) ? (c | 16'h0008) : c);
      fsm <= (m == 1);
      sam <= (m == 2);
      mon.thermal_shutdown_flag <= 1'b1;
      ck(3'h0);
      mon.thermal_shutdown_flag <= 1'b0;
      ck(3'h7);
    end
    {fsm, sam} <= 2'b00;
    host.wr(8'h00, c);
    mon.ov <= 1'b1;
    repeat (2) @(posedge clk);
    cmp("phase_drive", 16'h7, {13'h0, drv});
    ck(3'h0);
    mon.ov <= 1'b0;
    ck(3'h0);
    mon.ov_low <= 1'b1;
    ck(3'h7);
    r(8'h0a, 16'h0010, 16'h0010);
    host.wr(8'h0a, 16'h0010);
    r(8'h0a, 16'h0010, 16'h0000);
    mon.div_uv <= 1'b1;
    ck(3'h0);
    mon.div_uv <= 1'b0;
    ck(3'h7);
    r(8'h0b, 16'h0001, 16'h0001);
    for (int k = 0; k < 2; k++)
    begin
      // let the old fault leave the synchroniser, else the set wins
      repeat (4) @(posedge clk);
      host.wr(8'h0b, 16'h0003);
      r(8'h0b, 16'h0002, 16'h0000);
      mon.hr_fail <= (k == 0);
      mon.cur_fail <= (k == 1);
      ck(3'h7);
      {mon.hr_fail, mon.cur_fail} <= 2'b00;
      r(8'h0b, 16'h0002, 16'h0002);
    end
    @(posedge clk);
    ser_err <= 1'b1;
    @(posedge clk);
    ser_err <= 1'b0;
    r(8'h0a, 16'h0004, 16'h0004);
    mon.pin <= 3'h5;
    host.wr(8'h00, c | 16'h0010);
    ck(3'h5);
    r(8'h0b, 16'h0700, 16'h0500);
    r(8'h0a, 16'h0700, 16'h0500);
    mon.pin <= 3'h2;
    ck(3'h2);
    r(8'h0b, 16'h0700, 16'h0200);
    for (int t = 0; t < 8; t++)
    begin
      sd = xs(sd);
      mon.temp_hi <= sd[7:0];
      host.wr(8'h00, c | (16'(t) << 5));
      ck(3'h7);
      r(8'h0a, 16'h0020, {10'h0, sd[t], 5'h0});
    end
    repeat (3) @(posedge clk);
    final_report();
  end
endmodule
`default_nettype wire

/* logic/bfd_consts.svh */
// constants for the booster diagnostic flag block
// assumes a 100 MHz clock and a 16-bit register port
`ifndef BFD_CONSTS_SVH
`define BFD_CONSTS_SVH
`define BFD_PHASES      3
`define BFD_AW          8
`define BFD_DW          16
`define BFD_CLK_NS      10
`define BFD_BLANK_NS    150000
`define BFD_BLANK_CYC   ((`BFD_BLANK_NS + `BFD_CLK_NS - 1) / `BFD_CLK_NS)
`define BFD_CNT_W       14
`define BFD_OFS_CTRL    8'h00
`define BFD_OFS_STA     8'h0a
`define BFD_OFS_STB     8'h0b
`define BFD_CTRL_RST    16'h0000
`define BFD_C_EN_LSB    0
`define BFD_C_AUTO      3
`define BFD_C_PINSEL    4
`define BFD_C_TSEL_LSB  5
`define BFD_C_UVT_LSB   8
`define BFD_C_SETP_LSB  11
`define BFD_A_TW        0
`define BFD_A_TSD       1
`define BFD_A_SER       2
`define BFD_A_HWR       3
`define BFD_A_OV        4
`define BFD_A_TOUT      5
`define BFD_A_ACT_LSB   8
`define BFD_B_DUV       0
`define BFD_B_DNOK      1
`define BFD_B_PIN_LSB   8
`endif

/* logic/bfd_flags.sv */
// diagnostic and protection flags with phase shutdown for a boost
// controller; monitor inputs are asynchronous comparator levels,
// serial_error is a one-cycle pulse from the serial port logic and
// the two mode inputs come from logic on the same clock.
// reset_n is the power-on reset.
`timescale 1ns/1ps
`default_nettype none
`include "bfd_consts.svh"

// Notes on behaviour
// - warning comparator sets a latched warning flag; drive unaffected
// - shutdown detection turns all phases off, sets latched shutdown flag
// - shutdown condition ends only when temperature is below warning level
// - after shutdown: auto restart if bit set, else phase enable rising edge
// - temperature output flag follows comparator chosen by 3-bit select
// - serial error pulse sets a latched serial error flag
// - hardware reset flag set by power-on reset only
// - overvoltage sets latched flag and turns the booster off
// - booster restarts once boost voltage is below reactivation level
// - divider undervoltage sets latched flag and turns booster off
// - headroom or current fault sets latched gate-drive fault flag
// - gate-drive undervoltage turns the booster off
// - gate-drive undervoltage ignored for 150 us after power-on
// - 3-bit threshold relative to 4-bit setpoint; zero disables lockout
// - live per-phase active flag, distinct from the enable bit
// - live per-pin level flag of each enable pin
// - pin mode: phase runs only with enable bit and pin both high
// - manual restart needs shutdown flag cleared; modes force auto
module bfd_flags #(
  parameter int BLANK_CYC = `BFD_BLANK_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire bfd_pkg::bfd_bus_type       bus,
  output logic [`BFD_DW-1:0]              read_data,
  input  wire bfd_pkg::bfd_mon_type       mon,
  input  wire logic                       serial_error,
  input  wire logic                       fail_safe_mode,
  input  wire logic                       stand_alone_mode,
  output logic [`BFD_PHASES-1:0]          phase_drive,
  output logic [2:0]                      gate_drive_uv_threshold,
  output logic [3:0]                      gate_drive_setpoint
);

  localparam int PH = `BFD_PHASES;
  localparam logic [`BFD_CNT_W-1:0] BLANK_LAST =
    `BFD_CNT_W'(BLANK_CYC - 1);

  bfd_pkg::bfd_state_type st_ff;
  bfd_pkg::bfd_state_type nxt_st;

  logic [PH-1:0]  en_bit;
  logic           auto_rcv;
  logic           pin_sel;
  logic [2:0]     tsel;
  logic [2:0]     uv_thr;
  logic           temp_out;
  logic           drv_uv_now;
  logic           off_all;
  logic           wr_a;
  logic           wr_b;
  logic [PH-1:0]  rise;

  // a change counts once the second and third stage agree
  function automatic bfd_pkg::bfd_mon_type settle(
    input bfd_pkg::bfd_mon_type a,
    input bfd_pkg::bfd_mon_type b,
    input bfd_pkg::bfd_mon_type held
  );
    settle = (a & b) | (held & (a | b));
  endfunction

  function automatic logic clr_bit(
    input logic            wr_hit,
    input logic [`BFD_DW-1:0] d,
    input int              pos
  );
    clr_bit = wr_hit & d[pos];
  endfunction

  always_comb
  begin
    en_bit   = st_ff.ctrl[`BFD_C_EN_LSB +: PH];
    pin_sel  = st_ff.ctrl[`BFD_C_PINSEL];
    tsel     = st_ff.ctrl[`BFD_C_TSEL_LSB +: 3];
    uv_thr   = st_ff.ctrl[`BFD_C_UVT_LSB +: 3];
    auto_rcv = st_ff.ctrl[`BFD_C_AUTO] | fail_safe_mode
               | stand_alone_mode;
    temp_out = st_ff.stab.temp_hi[tsel];
    drv_uv_now = st_ff.stab.drv_uv & st_ff.blank_done
                 & (uv_thr != 3'h0);
    off_all  = st_ff.tsd_act | st_ff.ov_off | st_ff.stab.div_uv
               | drv_uv_now;
    wr_a     = bus.wr & (bus.addr == `BFD_OFS_STA);
    wr_b     = bus.wr & (bus.addr == `BFD_OFS_STB);
    rise     = en_bit & ~st_ff.en_prev;
    nxt_st   = st_ff;

    // three-stage synchroniser; s1 is read only by s2
    nxt_st.s1   = mon;
    nxt_st.s2   = st_ff.s1;
    nxt_st.s3   = st_ff.s2;
    nxt_st.stab = settle(st_ff.s2, st_ff.s3, st_ff.stab);

    if (bus.wr && bus.addr == `BFD_OFS_CTRL)
    begin
      nxt_st.ctrl = bus.wdata;
    end

    // latched flags: write one to clear, a new event wins the cycle
    nxt_st.tw = st_ff.stab.tw
      | (st_ff.tw & ~clr_bit(wr_a, bus.wdata, `BFD_A_TW));
    nxt_st.thermal_shutdown_flag = st_ff.stab.thermal_shutdown_flag
      | (st_ff.thermal_shutdown_flag & ~clr_bit(wr_a, bus.wdata, `BFD_A_TSD));
    nxt_st.ser = serial_error
      | (st_ff.ser & ~clr_bit(wr_a, bus.wdata, `BFD_A_SER));
    nxt_st.hardware_reset_flag =
      st_ff.hardware_reset_flag & ~clr_bit(wr_a, bus.wdata, `BFD_A_HWR);
    nxt_st.ov = st_ff.stab.ov
      | (st_ff.ov & ~clr_bit(wr_a, bus.wdata, `BFD_A_OV));
    nxt_st.duv = st_ff.stab.div_uv
      | (st_ff.duv & ~clr_bit(wr_b, bus.wdata, `BFD_B_DUV));
    nxt_st.dnok = st_ff.stab.hr_fail | st_ff.stab.cur_fail
      | (st_ff.dnok & ~clr_bit(wr_b, bus.wdata, `BFD_B_DNOK));

    // shutdown holds until the die is back under the warning level
    nxt_st.tsd_act = st_ff.stab.thermal_shutdown_flag
      | (st_ff.tsd_act & st_ff.stab.tw);
    nxt_st.ov_off = st_ff.stab.ov
      | (st_ff.ov_off & ~st_ff.stab.ov_low);

    // blanking of the gate-drive lockout after power-on
    if (!st_ff.blank_done)
    begin
      nxt_st.blank_cnt = st_ff.blank_cnt + `BFD_CNT_W'(1);
      nxt_st.blank_done = (st_ff.blank_cnt == BLANK_LAST);
    end

    nxt_st.en_prev = en_bit;
    for (int i = 0; i < PH; i++)
    begin
      // manual restart needs a fresh enable edge with the flag cleared
      if (st_ff.tsd_act)
      begin
        nxt_st.blocked[i] = 1'b1;
      end
      else if (auto_rcv || (rise[i] && !st_ff.thermal_shutdown_flag))
      begin
        nxt_st.blocked[i] = 1'b0;
      end
      nxt_st.drive[i] = en_bit[i] & (~pin_sel | st_ff.stab.pin[i])
        & ~off_all & ~st_ff.blocked[i];
    end

    // read data stands for one cycle only; unmapped reads give zero
    nxt_st.rdata = '0;
    if (bus.rd)
    begin
      unique case (bus.addr)
        `BFD_OFS_CTRL:
          nxt_st.rdata = st_ff.ctrl;
        `BFD_OFS_STA:
        begin
          nxt_st.rdata[`BFD_A_TW]   = st_ff.tw;
          nxt_st.rdata[`BFD_A_TSD]  = st_ff.thermal_shutdown_flag;
          nxt_st.rdata[`BFD_A_SER]  = st_ff.ser;
          nxt_st.rdata[`BFD_A_HWR]  = st_ff.hardware_reset_flag;
          nxt_st.rdata[`BFD_A_OV]   = st_ff.ov;
          nxt_st.rdata[`BFD_A_TOUT] = temp_out;
          nxt_st.rdata[`BFD_A_ACT_LSB +: PH] = st_ff.drive;
        end
        `BFD_OFS_STB:
        begin
          nxt_st.rdata[`BFD_B_DUV]  = st_ff.duv;
          nxt_st.rdata[`BFD_B_DNOK] = st_ff.dnok;
          nxt_st.rdata[`BFD_B_PIN_LSB +: PH] = st_ff.stab.pin;
        end
        default:
          nxt_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_ff      <= '0;
      st_ff.ctrl <= `BFD_CTRL_RST;
      st_ff.hardware_reset_flag  <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  always_comb
  begin
    read_data               = st_ff.rdata;
    phase_drive             = st_ff.drive;
    gate_drive_uv_threshold = st_ff.ctrl[`BFD_C_UVT_LSB +: 3];
    gate_drive_setpoint     = st_ff.ctrl[`BFD_C_SETP_LSB +: 4];
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  chk_warn_latched: assert property (
    st_ff.stab.tw |=> st_ff.tw)
    else $error("warning flag not latched");

  chk_tsd_drive_off: assert property (
    st_ff.stab.thermal_shutdown_flag |=> ##1 (st_ff.drive == '0))
    else $error("phases run during thermal shutdown");

  chk_tsd_hysteresis: assert property (
    (st_ff.tsd_act && st_ff.stab.tw) |=> st_ff.tsd_act)
    else $error("shutdown left above warning level");

  chk_auto_restart: assert property (
    (st_ff.blocked[0] && !st_ff.tsd_act && st_ff.ctrl[`BFD_C_AUTO])
      |=> !st_ff.blocked[0])
    else $error("auto recovery did not release phase");

  chk_manual_hold: assert property (
    (st_ff.blocked[0] && !auto_rcv && st_ff.thermal_shutdown_flag && !st_ff.tsd_act)
      |=> st_ff.blocked[0])
    else $error("manual restart with flag still set");

  chk_serial_latch: assert property (
    serial_error |=> st_ff.ser)
    else $error("serial error not latched");

  chk_ov_recover: assert property (
    (st_ff.ov_off && st_ff.stab.ov_low && !st_ff.stab.ov)
      |=> !st_ff.ov_off)
    else $error("overvoltage off not released");

  // the blanking window must end exactly after BLANK_CYC counted cycles
  chk_uv_blanking: assert property (
    $rose(st_ff.blank_done) |-> st_ff.blank_cnt == `BFD_CNT_W'(BLANK_CYC))
    else $error("lockout blanking length wrong");

  chk_pin_gate: assert property (
    (pin_sel && !st_ff.stab.pin[0]) |=> !st_ff.drive[0])
    else $error("phase runs with pin low");

  chk_hwr_sticky: assert property (
    (!st_ff.hardware_reset_flag) |=> !st_ff.hardware_reset_flag)
    else $error("reset flag set outside power-on");

  chk_read_tout: assert property (
    (bus.rd && bus.addr == `BFD_OFS_STA)
      |=> read_data[`BFD_A_TOUT] == $past(temp_out))
    else $error("temperature output misread");

  cov_tsd_cycle: cover property (
    st_ff.tsd_act ##[1:1000] !st_ff.tsd_act);
  cov_ov_cycle: cover property (
    st_ff.ov_off ##[1:1000] !st_ff.ov_off);
  cov_manual_edge: cover property (
    st_ff.blocked[0] && !st_ff.tsd_act ##1 !st_ff.blocked[0]);

endmodule
`default_nettype wire

/* logic/bfd_pkg.sv */
// types for the booster diagnostic flag block
// widths come from bfd_consts.svh
`default_nettype none
`include "bfd_consts.svh"
package bfd_pkg;
  typedef struct packed {
    logic                    wr;
    logic                    rd;
    logic [`BFD_AW-1:0]      addr;
    logic [`BFD_DW-1:0]      wdata;
  } bfd_bus_type;
  typedef struct packed {
    logic                    tw;
    logic                    thermal_shutdown_flag;
    logic                    ov;
    logic                    ov_low;
    logic                    div_uv;
    logic                    hr_fail;
    logic                    cur_fail;
    logic                    drv_uv;
    logic [7:0]              temp_hi;
    logic [`BFD_PHASES-1:0]  pin;
  } bfd_mon_type;
  typedef struct packed {
    bfd_mon_type             s1;
    bfd_mon_type             s2;
    bfd_mon_type             s3;
    bfd_mon_type             stab;
    logic [`BFD_DW-1:0]      ctrl;
    logic                    tw;
    logic                    thermal_shutdown_flag;
    logic                    ser;
    logic                    hardware_reset_flag;
    logic                    ov;
    logic                    duv;
    logic                    dnok;
    logic                    tsd_act;
    logic                    ov_off;
    logic [`BFD_PHASES-1:0]  blocked;
    logic [`BFD_PHASES-1:0]  en_prev;
    logic [`BFD_PHASES-1:0]  drive;
    logic [`BFD_CNT_W-1:0]   blank_cnt;
    logic                    blank_done;
    logic [`BFD_DW-1:0]      rdata;
  } bfd_state_type;
endpackage
`default_nettype wire
